// ==== rtl/supervisor_pkg.sv ====
// Constants, timing figures and state codes for the supply and watchdog
// supervisor.
// Assumes a single 50 MHz core clock and an asynchronous active-low reset.
package supervisor_pkg;

    localparam int CLK_HZ = 50_000_000;
    localparam int CYCLES_PER_MS = CLK_HZ / 1000;

    // Reset active time, least figure, in milliseconds.
    localparam int RESET_ACTIVE_MS = 140;
    localparam int RESET_ACTIVE_CYCLES = CYCLES_PER_MS * RESET_ACTIVE_MS;

    // Watchdog timeout, typical figure, in milliseconds.
    localparam int WD_TIMEOUT_MS = 1600;
    localparam int WD_TIMEOUT_CYCLES = CYCLES_PER_MS * WD_TIMEOUT_MS;

    // Wide enough for the longest count above.
    localparam int TIMER_W = 27;

    // Output levels after reset.
    localparam logic RESET_N_RST = 1'b0;
    localparam logic RESET_RST = 1'b1;
    localparam logic FAULT_N_RST = 1'b1;

    // Decoded service input levels.
    typedef enum logic [1:0] {
        LVL_MID = 2'h0,
        LVL_LOW = 2'h1,
        LVL_HIGH = 2'h2
    } service_level_t;

    typedef enum logic [3:0] {
        ST_SUPPLY_LOW = 4'h1,
        ST_STRETCH = 4'h2,
        ST_RUN = 4'h4,
        ST_WD_PULSE = 4'h8
    } supervisor_state_t;

endpackage : supervisor_pkg

// ==== rtl/pin_sync.sv ====
// Two-flop synchroniser for asynchronous pin levels.
// Assumes inputs are static levels; short glitches may be missed.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_in,
    output logic [WIDTH-1:0] level_q
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] level_d;

    always_comb begin
        meta_d = pin_in;
        level_d = meta_q;
    end

    // The first stage feeds only the second stage.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            level_q <= '0;
        end else begin
            meta_q <= meta_d;
            level_q <= level_d;
        end
    end

endmodule : pin_sync

// ==== rtl/cycle_timer.sv ====
// Up-counter that pulses done on the cycle it reaches limit.
// Assumes limit is at least one; the count wraps to zero on done.
`timescale 1ns/1ps
module cycle_timer #(
    parameter int WIDTH = 27
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic clear,
    input wire logic run,
    input wire logic [WIDTH-1:0] limit,
    output logic done
);

    localparam logic [WIDTH-1:0] ONE = WIDTH'(1);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;

    always_comb begin
        done = run && !clear && ((count_q + ONE) == limit);
        if (clear || done) begin
            count_d = '0;
        end else if (run) begin
            count_d = count_q + ONE;
        end else begin
            count_d = count_q;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
        end else begin
            count_q <= count_d;
        end
    end

endmodule : cycle_timer

// ==== rtl/supply_reset_watchdog.sv ====
// Supply reset stretcher and three-level watchdog for a processor.
// Assumes the supply comparator and the two service level comparators
// arrive as asynchronous pins; all outputs are registered.
//
// Functional notes
// R1 - Reset low output held low while supply is low.
// R2 - After supply recovers, reset stays low at least 140 ms.
// R3 - Unserviced enabled watchdog asserts reset for at least 140 ms.
// R4 - Static service input past timeout pulses reset and drops fault.
// R5 - Both service edges clear the watchdog timer, starting a new period.
// R6 - Floating or mid-level service input disables the watchdog.
// R7 - Active-high reset is always the complement of reset low.
// R8 - Fault output returns high on the next service edge.
// R9 - Fault output stays high while the watchdog is disabled.
// R10 - Fault output forced high while supply is low.
// R11 - Static service input repeats reset pulses once per timeout.
// R12 - Processor toggles service input at least every 1.6 seconds.
// R13 - Systems without watchdog leave the service input unconnected.
// R14 - Timeout 1.0 to 2.25 s; reset active 140 to 280 ms.
// R15 - Timer held clear in supply reset, restarted after each timeout.
`timescale 1ns/1ps
module supply_reset_watchdog
    import supervisor_pkg::*;
#(
    parameter int RESET_CYCLES = RESET_ACTIVE_CYCLES,
    parameter int TIMEOUT_CYCLES = WD_TIMEOUT_CYCLES
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic supply_low,
    input wire logic service_above_high,
    input wire logic service_below_low,
    output logic reset_out_n_q,
    output logic reset_out_q,
    output logic watchdog_fault_output_n
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and level decode.

    logic [2:0] pins_s;
    logic supply_low_s;
    logic above_s;
    logic below_s;

    pin_sync #(
        .WIDTH(3)
    ) u_pin_sync (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .pin_in({supply_low, service_above_high, service_below_low}),
        .level_q(pins_s)
    );

    assign supply_low_s = pins_s[2];
    assign above_s = pins_s[1];
    assign below_s = pins_s[0];

    function automatic service_level_t decode_level(input logic hi,
                                                    input logic lo);
        // Both comparators set cannot happen on a sane wire.
        if (hi && !lo) begin
            decode_level = LVL_HIGH;
        end else if (lo && !hi) begin
            decode_level = LVL_LOW;
        end else begin
            decode_level = LVL_MID;
        end
    endfunction : decode_level

    service_level_t level;
    logic wd_enable;

    always_comb begin
        level = decode_level(above_s, below_s);
        // R6 mid disables watchdog
        wd_enable = (level != LVL_MID);
    end

    ////////////////////////////////////////////////////////////////////////
    // Service edge detection.

    service_level_t last_q;
    service_level_t last_d;
    logic last_valid_q;
    logic last_valid_d;
    logic service_edge;

    always_comb begin
        last_d = last_q;
        last_valid_d = wd_enable;
        if (wd_enable) begin
            last_d = level;
        end
        // R5 edge in either direction
        service_edge = wd_enable && last_valid_q && (level != last_q);
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            last_q <= LVL_MID;
            last_valid_q <= 1'b0;
        end else begin
            last_q <= last_d;
            last_valid_q <= last_valid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Timers.

    supervisor_state_t state_q;
    supervisor_state_t state_d;
    logic pulse_run;
    logic pulse_clear;
    logic pulse_done;
    logic wd_run;
    logic wd_clear;
    logic wd_timeout;

    always_comb begin
        pulse_run = (state_q == ST_STRETCH) || (state_q == ST_WD_PULSE);
        pulse_clear = !pulse_run || wd_timeout || supply_low_s;
        // R15 timer held in supply reset
        wd_run = wd_enable &&
                 ((state_q == ST_RUN) || (state_q == ST_WD_PULSE));
        // R5 edge restarts period
        wd_clear = !wd_run || service_edge || supply_low_s;
    end

    // R2 R3 R14 reset active time
    cycle_timer #(
        .WIDTH(TIMER_W)
    ) u_pulse_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(pulse_clear),
        .run(pulse_run),
        .limit(TIMER_W'(RESET_CYCLES)),
        .done(pulse_done)
    );

    // R14 R15 watchdog period
    cycle_timer #(
        .WIDTH(TIMER_W)
    ) u_wd_timer (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .clear(wd_clear),
        .run(wd_run),
        .limit(TIMER_W'(TIMEOUT_CYCLES)),
        .done(wd_timeout)
    );

    ////////////////////////////////////////////////////////////////////////
    // Supervisor state and outputs.

    logic reset_n_d;
    logic reset_d;
    logic fault_n_d;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_SUPPLY_LOW: begin
                if (!supply_low_s) begin
                    state_d = ST_STRETCH;
                end
            end
            ST_STRETCH: begin
                // R2 stretch after recovery
                if (pulse_done) begin
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                // R3 R4 timeout pulses reset
                if (wd_timeout) begin
                    state_d = ST_WD_PULSE;
                end
            end
            ST_WD_PULSE: begin
                // R11 pulse ends, period continues
                if (pulse_done) begin
                    state_d = ST_RUN;
                end
            end
        endcase
        // R1 supply low overrides all
        if (supply_low_s) begin
            state_d = ST_SUPPLY_LOW;
        end

        reset_n_d = (state_d == ST_RUN);
        // R7 complement output
        reset_d = !reset_n_d;

        fault_n_d = watchdog_fault_output_n;
        if (supply_low_s) begin
            // R10 fault high on low supply
            fault_n_d = 1'b1;
        end else if (!wd_enable) begin
            // R9 fault high while disabled
            fault_n_d = 1'b1;
        end else if (service_edge) begin
            // R8 edge returns fault high
            fault_n_d = 1'b1;
        end else if (wd_timeout) begin
            // R4 timeout drops fault
            fault_n_d = 1'b0;
        end
    end

    // Outputs share one register stage so the two resets never skew.
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_q <= ST_SUPPLY_LOW;
            reset_out_n_q <= RESET_N_RST;
            reset_out_q <= RESET_RST;
            watchdog_fault_output_n <= FAULT_N_RST;
        end else begin
            state_q <= state_d;
            reset_out_n_q <= reset_n_d;
            reset_out_q <= reset_d;
            watchdog_fault_output_n <= fault_n_d;
        end
    end

endmodule : supply_reset_watchdog

// ==== test/supervisor_checker_asserts.sv ====
// Port checks for the supply and watchdog supervisor.
// Assumes it is bound to every supply_reset_watchdog instance.
`timescale 1ns/1ps
module supervisor_checker #(
    parameter int RESET_CYCLES = 20,
    parameter int TIMEOUT_CYCLES = 100
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic supply_low,
    input wire logic service_above_high,
    input wire logic service_below_low,
    input wire logic reset_out_n_q,
    input wire logic reset_out_q,
    input wire logic watchdog_fault_output_n
);
    logic above_q, below_q, mid, moved, edge_seen;
    int low_q, low_d, quiet_q, quiet_d, run_q, run_d, mid_q, mid_d;
    assign mid = service_above_high == service_below_low;
    assign moved = service_above_high != above_q
        || service_below_low != below_q;
    assign edge_seen = moved && !mid && above_q != below_q;
    // The mid, quiet and run counters saturate so that long idle spells cannot wrap.
    always_comb begin
        low_d = reset_out_n_q ? 0 : low_q + 1;
        mid_d = mid ? (mid_q < 8 ? mid_q + 1 : mid_q) : 0;
        quiet_d = moved ? 0 : (quiet_q < 9999 ? quiet_q + 1 : quiet_q);
        run_d = (moved || mid || supply_low || !reset_out_n_q) ? 0
            : (run_q < 9999 ? run_q + 1 : run_q);
    end
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            {above_q, below_q} <= 2'h0;
            {low_q, mid_q, quiet_q, run_q} <= '0;
        end else begin
            {above_q, below_q} <= {service_above_high, service_below_low};
            {low_q, mid_q, quiet_q, run_q} <= {low_d, mid_d, quiet_d, run_d};
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    property p_compl;
        reset_out_q == !reset_out_n_q;
    endproperty
    a_compl: assert property (p_compl)
        else $error("active-high reset is not the complement");
    property p_supply;
        supply_low [*3] |=> !reset_out_n_q && watchdog_fault_output_n;
    endproperty
    a_supply: assert property (p_supply)
        else $error("supply low did not force reset and fault level");
    property p_stretch;
        $rose(reset_out_n_q) |-> low_q >= RESET_CYCLES;
    endproperty
    a_stretch: assert property (p_stretch)
        else $error("reset released too early");
    property p_mid_fault;
        mid_q >= 4 |-> watchdog_fault_output_n;
    endproperty
    a_mid_fault: assert property (p_mid_fault)
        else $error("fault low while watchdog disabled");
    property p_mid_quiet;
        mid_q >= 4 && !supply_low && reset_out_n_q |=> reset_out_n_q;
    endproperty
    a_mid_quiet: assert property (p_mid_quiet)
        else $error("reset issued while watchdog disabled");
    property p_timeout;
        run_q == TIMEOUT_CYCLES + 8 |-> !watchdog_fault_output_n;
    endproperty
    a_timeout: assert property (p_timeout)
        else $error("no fault after static service input");
    property p_no_early;
        $fell(watchdog_fault_output_n) |-> quiet_q >= TIMEOUT_CYCLES - 2;
    endproperty
    a_no_early: assert property (p_no_early)
        else $error("fault before a full timeout");
    property p_clear;
        !watchdog_fault_output_n && edge_seen
            |-> ##[1:5] watchdog_fault_output_n;
    endproperty
    a_clear: assert property (p_clear)
        else $error("fault not cleared by service edge");
endmodule : supervisor_checker
bind supply_reset_watchdog supervisor_checker #(
    .RESET_CYCLES(RESET_CYCLES), .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) supervisor_checker_i (
    .core_clk(core_clk), .rst_n(rst_n), .supply_low(supply_low),
    .service_above_high(service_above_high),
    .service_below_low(service_below_low),
    .reset_out_n_q(reset_out_n_q), .reset_out_q(reset_out_q),
    .watchdog_fault_output_n(watchdog_fault_output_n)
);

// ==== test/proc_model.sv ====
// Processor model driving the three-level service pin.
// Assumes the bench changes mode just after a rising edge.
`timescale 1ns/1ps
module proc_model #(
    parameter int HALF_PERIOD = 40
) (
    input wire logic core_clk,
    input wire logic [1:0] mode,
    output logic service_above_high,
    output logic service_below_low
);
    int cnt = 0;
    logic lvl = 1'b0;
    always @(posedge core_clk) begin
        cnt <= (cnt == HALF_PERIOD - 1) ? 0 : cnt + 1;
        lvl <= (cnt == HALF_PERIOD - 1) ? !lvl : lvl;
    end
    always @(posedge core_clk) begin
        #2;
        case (mode)
            2'h0: {service_above_high, service_below_low} = 2'h0;
            2'h1: {service_above_high, service_below_low} = {lvl, !lvl};
            2'h2: {service_above_high, service_below_low} = 2'h2;
            default: {service_above_high, service_below_low} = 2'h1;
        endcase
    end
endmodule : proc_model

// ==== test/tb.sv ====
// Self-checking bench for the supply and watchdog supervisor.
// Assumes shortened counts; the processor model drives the service pin.
`timescale 1ns/1ps
module tb;
    localparam int RST_C = 20;
    localparam int TO_C = 100;
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic supply_low = 1'b0;
    logic [1:0] mode = 2'h0;
    logic service_above_high, service_below_low;
    logic reset_out_n_q, reset_out_q, watchdog_fault_output_n;
    int num_errors = 0;
    int checks_done = 0;
    int n, w;
    always #10 core_clk = !core_clk;
    supply_reset_watchdog #(.RESET_CYCLES(RST_C), .TIMEOUT_CYCLES(TO_C))
        supply_reset_watchdog_i (.core_clk(core_clk), .rst_n(rst_n),
        .supply_low(supply_low), .service_above_high(service_above_high),
        .service_below_low(service_below_low),
        .reset_out_n_q(reset_out_n_q), .reset_out_q(reset_out_q),
        .watchdog_fault_output_n(watchdog_fault_output_n));
    proc_model proc_model_i (.core_clk(core_clk), .mode(mode),
        .service_above_high(service_above_high),
        .service_below_low(service_below_low));
    task automatic close_out;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [31:0] exp,
            input logic [31:0] got);
        checks_done++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic step(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : step
    task automatic until_rst(input logic lvl, output int k);
        k = 0;
        while (reset_out_n_q !== lvl && k < 400) begin
            step(1);
            k++;
        end
        if (reset_out_n_q !== lvl) begin
            num_errors++;
            $display("ERROR reset level expected %0h seen %0h", lvl,
                reset_out_n_q);
        end
    endtask : until_rst
    task automatic t_reset;
        rst_n = 1'b0;
        step(2);
        chk("reset in reset", 0, reset_out_n_q);
        chk("high reset in reset", 1, reset_out_q);
        chk("fault in reset", 1, watchdog_fault_output_n);
        rst_n = 1'b1;
        until_rst(1'b1, n);
        chk("restart", 1, n >= RST_C && n <= 2 * RST_C);
    endtask : t_reset
    task automatic t_supply;
        mode = 2'h2;
        supply_low = 1'b1;
        step(6);
        chk("reset supply", 0, reset_out_n_q);
        chk("fault supply", 1, watchdog_fault_output_n);
        step(150);
        chk("reset held", 0, reset_out_n_q);
        supply_low = 1'b0;
        until_rst(1'b1, n);
        chk("stretch", 1, n >= RST_C && n <= 2 * RST_C);
        until_rst(1'b0, n);
        chk("timer held", 1, n >= TO_C - RST_C - 5);
        mode = 2'h1;
        until_rst(1'b1, n);
    endtask : t_supply
    task automatic t_quiet(input logic [1:0] m, input int k);
        int lows = 0;
        mode = m;
        repeat (k) begin
            step(1);
            lows += (reset_out_n_q !== 1'b1);
        end
        chk("no reset", 0, lows);
        chk("fault high", 1, watchdog_fault_output_n);
    endtask : t_quiet
    task automatic t_static(input logic [1:0] lvl, input logic by_supply);
        mode = lvl;
        until_rst(1'b0, n);
        chk("timeout", 1, n >= TO_C - 5 && n <= TO_C + 10);
        chk("fault", 0, watchdog_fault_output_n);
        until_rst(1'b1, w);
        chk("pulse", 1, w >= RST_C && w <= 2 * RST_C);
        until_rst(1'b0, n);
        chk("period", TO_C, n + w);
        if (by_supply) begin
            supply_low = 1'b1;
            step(5);
            chk("fault forced", 1, watchdog_fault_output_n);
            supply_low = 1'b0;
        end else begin
            mode = lvl ^ 2'h1;
            step(5);
            chk("fault edge", 1, watchdog_fault_output_n);
        end
        mode = 2'h1;
        until_rst(1'b1, n);
    endtask : t_static
    initial begin
        step(20);
        rst_n = 1'b1;
        until_rst(1'b1, n);
        chk("power-up", 1, n >= RST_C && n <= 2 * RST_C);
        chk("complement", 0, reset_out_q);
        t_supply();
        t_quiet(2'h1, 400);
        t_static(2'h2, 1'b0);
        t_static(2'h3, 1'b1);
        t_static(2'h2, 1'b0);
        t_quiet(2'h0, 300);
        t_reset();
        close_out();
    end
    initial begin
        step(6000);
        num_errors++;
        close_out();
    end
endmodule : tb
